// file: src/adc_cmd_pkg.sv
// Purpose: constants and types for the two-wire converter command controller
// Assumes: core clock of 25 MHz, converter core on its own clock
// Notes: selection field positions refer to the four-bit {mode, high, mid, low} view
package adc_cmd_pkg;
   // =====================================================
   // timing
   localparam int CLK_FREQ_MHZ = 25;
   localparam int PWRUP_TIME_NS = 1400;
   localparam int PWRUP_CYCLES = (PWRUP_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
   localparam int PWRUP_CNT_W = 6;
   localparam int SAMPLE_CYCLES = 4;
   // =====================================================
   // widths and fields
   localparam int RESULT_BITS = 12;
   localparam int BYTE_BITS = 8;
   localparam int CNT_W = 4;
   localparam int CHANNELS_FULL = 8;
   localparam int CHANNELS_SMALL = 4;
   localparam logic [4:0] TYPE_CODE = 5'h0b; // arbitrary value
   localparam int CMD_REF_POS = 3;
   localparam int CMD_CONV_POS = 2;
   localparam int SEL_MODE = 3;
   localparam int SEL_HI = 2;
   localparam int SEL_MID = 1;
   localparam int SEL_LO = 0;
   localparam logic [CNT_W-1:0] CNT_AT_LO = 4'h3;
   localparam logic [CNT_W-1:0] CNT_AT_CONV = 4'h5;
   localparam logic [CNT_W-1:0] CNT_LAST = 4'h7;
   localparam logic [CNT_W-1:0] CNT_FULL = 4'h8;
   localparam logic [1:0] STRAP_WAIT = 2'h3;
   // =====================================================
   // states
   typedef enum logic [2:0] {
      LINK_IDLE = 3'h0, LINK_ADDR = 3'h1, LINK_ADDR_ACK = 3'h3, LINK_CMD = 3'h2,
      LINK_CMD_ACK = 3'h6, LINK_TX = 3'h7, LINK_TX_ACK = 3'h5, LINK_IGNORE = 3'h4
   } link_state_t;
   typedef enum logic [1:0] {
      SAR_IDLE = 2'h0, SAR_SAMPLE = 2'h1, SAR_CONVERT = 2'h3, SAR_DONE = 2'h2
   } sar_state_t;
endpackage : adc_cmd_pkg

// file: src/sync_2ff.sv
// Purpose: two-flop synchroniser for levels and toggles
// Assumes: inputs are quasi-static relative to the destination clock
// Notes: only the second flop is visible outside
`timescale 1ns/1ps
`default_nettype none
module sync_2ff #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // crossing
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_q <= RESET_VAL;
         q <= RESET_VAL;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule : sync_2ff
`default_nettype wire

// file: src/sar_core.sv
// Purpose: successive-approximation sequencer on the converter clock
// Assumes: start_tgl already synchronised; cmp_high from comparator on conv_clk
// Notes: result held stable from done toggle until the next start
`timescale 1ns/1ps
`default_nettype none
module sar_core #(
   parameter int BITS = adc_cmd_pkg::RESULT_BITS,
   parameter int SAMPLE_LEN = adc_cmd_pkg::SAMPLE_CYCLES
) (
   // clock and reset
   input wire logic conv_clk,
   input wire logic rst,
   // control
   input wire logic start_tgl,
   input wire logic cmp_high,
   // converter side
   output logic sample_q,
   output logic [BITS-1:0] trial_q,
   output logic [BITS-1:0] result_q,
   output logic done_tgl_q
);
   import adc_cmd_pkg::*;

   localparam int SW = $clog2(SAMPLE_LEN + 1);
   localparam logic [SW-1:0] SAMPLE_LAST = SW'(SAMPLE_LEN - 1);
   localparam logic [BITS-1:0] MSB_MASK = {1'b1, {(BITS-1){1'b0}}};

   sar_state_t state_q;
   logic start_seen_q;
   logic [SW-1:0] samp_cnt_q;
   logic [BITS-1:0] mask_q;

   // keep trial bit when input is at or above the trial level
   wire start_edge = start_tgl != start_seen_q;
   wire [BITS-1:0] kept = cmp_high ? trial_q : (trial_q & ~mask_q);

   always_ff @(posedge conv_clk or posedge rst) begin
      if (rst) begin
         state_q <= SAR_IDLE;
         start_seen_q <= 1'b0;
         samp_cnt_q <= '0;
         mask_q <= '0;
         sample_q <= 1'b0;
         trial_q <= '0;
         result_q <= '0;
         done_tgl_q <= 1'b0;
      end else begin
         start_seen_q <= start_tgl;
         case (state_q)
            SAR_IDLE: if (start_edge) begin
               state_q <= SAR_SAMPLE;
               sample_q <= 1'b1;
               samp_cnt_q <= '0;
            end
            SAR_SAMPLE: if (samp_cnt_q == SAMPLE_LAST) begin
               state_q <= SAR_CONVERT;
               sample_q <= 1'b0;
               mask_q <= MSB_MASK;
               trial_q <= MSB_MASK;
            end else begin
               samp_cnt_q <= samp_cnt_q + 1'b1;
            end
            SAR_CONVERT: if (mask_q[0]) begin
               result_q <= kept;
               state_q <= SAR_DONE;
            end else begin
               mask_q <= mask_q >> 1;
               trial_q <= kept | (mask_q >> 1);
            end
            default: begin
               done_tgl_q <= ~done_tgl_q;
               state_q <= SAR_IDLE;
            end
         endcase
      end
   end
endmodule : sar_core
`default_nettype wire

// file: src/adc_cmd_ctrl.sv
// Purpose: two-wire slave, command decode and conversion sequencing for the converter
// Assumes: bus pins oversampled on clk; converter core on conv_clk
// Notes: sda is open drain; sda_oe high pulls the line low
`timescale 1ns/1ps
`default_nettype none
module adc_cmd_ctrl #(
   parameter int NUM_CHANNELS = adc_cmd_pkg::CHANNELS_FULL
) (
   // clocks and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic conv_clk,
   // two-wire bus
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   // address straps
   input wire logic address_select_high,
   input wire logic address_select_low,
   // analog front end
   input wire logic cmp_high,
   output logic [2:0] mux_pos_ch,
   output logic [2:0] mux_neg_ch,
   output logic mux_neg_common,
   output logic [adc_cmd_pkg::RESULT_BITS-1:0] dac_trial,
   output logic sample_hold,
   // power and status
   output logic converter_power,
   output logic reference_power,
   output logic conv_busy,
   output logic result_valid
);
   import adc_cmd_pkg::*;

   // =====================================================
   // pin and toggle synchronisers
   logic scl_s, sda_s;
   logic [1:0] strap_s;
   logic done_tgl_c, done_s;
   logic start_tgl_q, start_c;

   sync_2ff #(.WIDTH(2), .RESET_VAL(2'h3)) u_bus_sync (
      .clk(clk),
      .rst(rst),
      .d({scl_i, sda_i}),
      .q({scl_s, sda_s})
   );

   sync_2ff #(.WIDTH(2), .RESET_VAL(2'h0)) u_strap_sync (
      .clk(clk),
      .rst(rst),
      .d({address_select_high, address_select_low}),
      .q(strap_s)
   );

   sync_2ff #(.WIDTH(1), .RESET_VAL(1'b0)) u_done_sync (
      .clk(clk),
      .rst(rst),
      .d(done_tgl_c),
      .q(done_s)
   );

   sync_2ff #(.WIDTH(1), .RESET_VAL(1'b0)) u_start_sync (
      .clk(conv_clk),
      .rst(rst),
      .d(start_tgl_q),
      .q(start_c)
   );

   // =====================================================
   // converter core
   logic [RESULT_BITS-1:0] sar_result;
   sar_core #(.BITS(RESULT_BITS), .SAMPLE_LEN(SAMPLE_CYCLES)) u_sar (
      .conv_clk(conv_clk),
      .rst(rst),
      .start_tgl(start_c),
      .cmp_high(cmp_high),
      .sample_q(sample_hold),
      .trial_q(dac_trial),
      .result_q(sar_result),
      .done_tgl_q(done_tgl_c)
   );

   // =====================================================
   // address straps, caught after reset release
   logic [1:0] strap_cnt_q;
   logic [1:0] addr_sel_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         strap_cnt_q <= '0;
         addr_sel_q <= '0;
      end else if (strap_cnt_q != STRAP_WAIT) begin
         strap_cnt_q <= strap_cnt_q + 1'b1;
         addr_sel_q <= strap_s;
      end
   end

   // =====================================================
   // bus conditions
   logic scl_p_q, sda_p_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_p_q <= scl_s;
         sda_p_q <= sda_s;
      end
   end

   wire start_cond = scl_s & scl_p_q & sda_p_q & ~sda_s;
   wire stop_cond = scl_s & scl_p_q & ~sda_p_q & sda_s;
   wire scl_rise = scl_s & ~scl_p_q;
   wire scl_fall = ~scl_s & scl_p_q;

   // =====================================================
   // link state
   link_state_t state_q, state_d;
   logic [CNT_W-1:0] bit_cnt_q, bit_cnt_d;
   logic [BYTE_BITS-1:0] shift_q, shift_d;
   logic ack_on_q, ack_on_d;
   logic rw_q, rw_d;
   logic mack_q, mack_d;
   logic byte_idx_q, byte_idx_d;
   logic sda_oe_q, sda_oe_d;
   logic sda_o_q;
   logic [RESULT_BITS-1:0] snap_q;

   wire [BYTE_BITS-1:0] rx_byte = {shift_q[BYTE_BITS-2:0], sda_s};
   wire [6:0] own_addr = {TYPE_CODE, addr_sel_q};
   wire addr_match = shift_q[BYTE_BITS-2:0] == own_addr;
   wire last_bit = bit_cnt_q == CNT_LAST;
   wire addr_hit = (state_q == LINK_ADDR) & scl_rise & last_bit & addr_match;
   wire addr_wr_hit = addr_hit & ~sda_s;
   wire read_hit = addr_hit & sda_s;
   wire cmd_rise = (state_q == LINK_CMD) & scl_rise;
   wire ch_bit_ev = cmd_rise & (bit_cnt_q == CNT_AT_LO);
   wire pwr_bit_ev = cmd_rise & (bit_cnt_q == CNT_AT_CONV);
   wire cmd_done_ev = cmd_rise & last_bit;

   // result bytes, high byte first
   wire [BYTE_BITS-1:0] byte_hi = {{(2 * BYTE_BITS - RESULT_BITS){1'b0}}, snap_q[RESULT_BITS-1:BYTE_BITS]};
   wire [BYTE_BITS-1:0] byte_lo = snap_q[BYTE_BITS-1:0];
   wire [BYTE_BITS-1:0] next_byte = byte_idx_q ? byte_hi : byte_lo;

   always_comb begin
      state_d = state_q;
      bit_cnt_d = bit_cnt_q;
      shift_d = shift_q;
      ack_on_d = ack_on_q;
      rw_d = rw_q;
      mack_d = mack_q;
      byte_idx_d = byte_idx_q;
      sda_oe_d = sda_oe_q;
      if (stop_cond) begin
         state_d = LINK_IDLE;
         sda_oe_d = 1'b0;
         ack_on_d = 1'b0;
      end else if (start_cond) begin
         state_d = LINK_ADDR;
         bit_cnt_d = '0;
         sda_oe_d = 1'b0;
         ack_on_d = 1'b0;
      end else begin
         case (state_q)
            LINK_ADDR, LINK_CMD: if (scl_rise) begin
               shift_d = rx_byte;
               bit_cnt_d = bit_cnt_q + 1'b1;
               if (last_bit) begin
                  if (state_q == LINK_CMD) begin
                     state_d = LINK_CMD_ACK;
                  end else if (addr_match) begin
                     state_d = LINK_ADDR_ACK;
                     rw_d = sda_s;
                  end else begin
                     state_d = LINK_IGNORE;
                  end
               end
            end
            LINK_ADDR_ACK, LINK_CMD_ACK: if (scl_fall) begin
               if (!ack_on_q) begin
                  ack_on_d = 1'b1;
                  sda_oe_d = 1'b1;
               end else begin
                  ack_on_d = 1'b0;
                  bit_cnt_d = '0;
                  if (state_q == LINK_ADDR_ACK && rw_q) begin
                     state_d = LINK_TX;
                     byte_idx_d = 1'b0;
                     shift_d = byte_hi;
                     sda_oe_d = ~byte_hi[BYTE_BITS-1];
                  end else begin
                     state_d = LINK_CMD;
                     sda_oe_d = 1'b0;
                  end
               end
            end
            LINK_TX: if (scl_rise) begin
               bit_cnt_d = bit_cnt_q + 1'b1;
            end else if (scl_fall) begin
               if (bit_cnt_q == CNT_FULL) begin
                  state_d = LINK_TX_ACK;
                  sda_oe_d = 1'b0;
               end else begin
                  shift_d = {shift_q[BYTE_BITS-2:0], 1'b0};
                  sda_oe_d = ~shift_q[BYTE_BITS-2];
               end
            end
            LINK_TX_ACK: if (scl_rise) begin
               mack_d = ~sda_s;
               if (sda_s) begin
                  state_d = LINK_IGNORE;
               end
            end else if (scl_fall && mack_q) begin
               mack_d = 1'b0;
               byte_idx_d = ~byte_idx_q;
               bit_cnt_d = '0;
               shift_d = next_byte;
               sda_oe_d = ~next_byte[BYTE_BITS-1];
               state_d = LINK_TX;
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= LINK_IDLE;
         bit_cnt_q <= '0;
         shift_q <= '0;
         ack_on_q <= 1'b0;
         rw_q <= 1'b0;
         mack_q <= 1'b0;
         byte_idx_q <= 1'b0;
         sda_oe_q <= 1'b0;
         sda_o_q <= 1'b0;
      end else begin
         state_q <= state_d;
         bit_cnt_q <= bit_cnt_d;
         shift_q <= shift_d;
         ack_on_q <= ack_on_d;
         rw_q <= rw_d;
         mack_q <= mack_d;
         byte_idx_q <= byte_idx_d;
         sda_oe_q <= sda_oe_d;
      end
   end

   // =====================================================
   // channel decode from {mode, high, mid, low}
   wire [3:0] sel_bits = {shift_q[2:0], sda_s};
   wire [1:0] pair = {sel_bits[SEL_MID], sel_bits[SEL_LO]};
   wire [2:0] even_ch = {pair, 1'b0};
   wire [2:0] odd_ch = {pair, 1'b1};
   wire [2:0] dif_pos = sel_bits[SEL_HI] ? odd_ch : even_ch;
   wire [2:0] dif_neg = sel_bits[SEL_HI] ? even_ch : odd_ch;
   wire [2:0] se_ch = {sel_bits[SEL_MID], sel_bits[SEL_LO], sel_bits[SEL_HI]};
   wire sel_mode = sel_bits[SEL_MODE];
   wire sel_legal = (NUM_CHANNELS > CHANNELS_SMALL) || !sel_bits[SEL_MID];
   logic [2:0] mux_pos_q, mux_neg_q;
   logic mux_com_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mux_pos_q <= '0;
         mux_neg_q <= '0;
         mux_com_q <= 1'b0;
      end else if (ch_bit_ev && sel_legal) begin
         mux_pos_q <= sel_mode ? se_ch : dif_pos;
         mux_neg_q <= sel_mode ? 3'h0 : dif_neg;
         mux_com_q <= sel_mode;
      end
   end

   // =====================================================
   // reference power
   logic ref_on_q, ref_arm_q;
   wire ref_bit = rx_byte[CMD_REF_POS];

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ref_on_q <= 1'b0;
         ref_arm_q <= 1'b0;
      end else if (cmd_done_ev && !ref_bit) begin
         ref_on_q <= 1'b0;
         ref_arm_q <= 1'b0;
      end else if (cmd_done_ev && !ref_on_q) begin
         ref_arm_q <= 1'b1;
      end else if ((start_cond || stop_cond) && ref_arm_q) begin
         ref_on_q <= 1'b1;
         ref_arm_q <= 1'b0;
      end
   end

   // =====================================================
   // converter power and conversion launch
   logic wr_session_q, keep_on_q, conv_pwr_q, conv_pend_q, busy_q, done_seen_q, valid_q;
   logic [PWRUP_CNT_W-1:0] pwr_cnt_q;
   logic [RESULT_BITS-1:0] result_q;

   wire pwr_ready = pwr_cnt_q == PWRUP_CNT_W'(PWRUP_CYCLES);
   wire launch = conv_pend_q & pwr_ready & ~busy_q;
   wire done_ev = done_s != done_seen_q;
   wire conv_pwr_d = wr_session_q | keep_on_q | conv_pend_q | busy_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_session_q <= 1'b0;
         keep_on_q <= 1'b0;
         conv_pwr_q <= 1'b0;
      end else begin
         wr_session_q <= addr_wr_hit | (wr_session_q & ~start_cond & ~stop_cond);
         keep_on_q <= pwr_bit_ev ? sda_s : keep_on_q;
         conv_pwr_q <= conv_pwr_d;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pwr_cnt_q <= '0;
      end else if (!conv_pwr_q) begin
         pwr_cnt_q <= '0;
      end else if (!pwr_ready) begin
         pwr_cnt_q <= pwr_cnt_q + 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         conv_pend_q <= 1'b0;
         busy_q <= 1'b0;
         start_tgl_q <= 1'b0;
      end else begin
         conv_pend_q <= ch_bit_ev | (conv_pend_q & ~launch);
         busy_q <= launch | (busy_q & ~done_ev);
         start_tgl_q <= start_tgl_q ^ launch;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         done_seen_q <= 1'b0;
         valid_q <= 1'b0;
         result_q <= '0;
         snap_q <= '0;
      end else begin
         done_seen_q <= done_s;
         valid_q <= valid_q | done_ev;
         result_q <= done_ev ? sar_result : result_q;
         snap_q <= read_hit ? result_q : snap_q;
      end
   end

   // =====================================================
   // outputs
   assign sda_o = sda_o_q;
   assign sda_oe = sda_oe_q;
   assign mux_pos_ch = mux_pos_q;
   assign mux_neg_ch = mux_neg_q;
   assign mux_neg_common = mux_com_q;
   assign converter_power = conv_pwr_q;
   assign reference_power = ref_on_q;
   assign conv_busy = busy_q;
   assign result_valid = valid_q;
endmodule : adc_cmd_ctrl
`default_nettype wire

// file: verification/adc_cmd_ctrl_monitor.sv
// Purpose: port checks for the converter command controller
// Assumes: bound to adc_cmd_ctrl, core clock domain only
// Notes: sample_hold is sampled on clk
`timescale 1ns/1ps
`default_nettype none
module adc_cmd_ctrl_monitor (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // bus
   input wire logic scl_i,
   input wire logic sda_o,
   input wire logic sda_oe,
   // mux
   input wire logic [2:0] mux_pos_ch,
   input wire logic [2:0] mux_neg_ch,
   input wire logic mux_neg_common,
   // status
   input wire logic sample_hold,
   input wire logic converter_power,
   input wire logic reference_power,
   input wire logic conv_busy,
   input wire logic result_valid
);
   import adc_cmd_pkg::*;
   logic [5:0] pwr_q;
   logic [5:0] pwr_d;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // ====
   // powered cycle count, saturating
   assign pwr_d = !converter_power ? 6'h00 : pwr_q + {5'h00, pwr_q != 6'h3f};
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pwr_q <= 6'h00;
      end else begin
         pwr_q <= pwr_d;
      end
   end
   // ====
   // properties
   property p_ref_reset; $fell(rst) |-> !reference_power; endproperty
   property p_ref_on; $rose(reference_power) |-> scl_i; endproperty
   property p_sda_change; $changed(sda_oe) |-> !scl_i; endproperty
   property p_sda_low; sda_o == 1'b0; endproperty
   property p_launch; $rose(conv_busy) |-> converter_power && int'(pwr_q) >= PWRUP_CYCLES - 1; endproperty
   property p_conv_len; $rose(conv_busy) |-> ##[5:20] !conv_busy; endproperty
   property p_sample; sample_hold |-> conv_busy && converter_power; endproperty
   property p_valid_hold; result_valid |=> result_valid; endproperty
   property p_valid_rise; $rose(result_valid) |-> $fell(conv_busy); endproperty
   property p_mux_diff; !mux_neg_common && mux_pos_ch != mux_neg_ch |-> mux_neg_ch == (mux_pos_ch ^ 3'h1); endproperty
   property p_mux_single; mux_neg_common |-> mux_neg_ch == 3'h0; endproperty
   a_ref_reset: assert property (p_ref_reset) else $error("reference on after reset");
   a_ref_on: assert property (p_ref_on) else $error("reference on outside bus condition");
   a_sda_change: assert property (p_sda_change) else $error("sda moved while scl high");
   a_sda_low: assert property (p_sda_low) else $error("sda driven high");
   a_launch: assert property (p_launch) else $error("launch before power up");
   a_conv_len: assert property (p_conv_len) else $error("conversion too long");
   a_sample: assert property (p_sample) else $error("sampling while idle");
   a_valid_hold: assert property (p_valid_hold) else $error("result valid dropped");
   a_valid_rise: assert property (p_valid_rise) else $error("valid without conversion");
   a_mux_diff: assert property (p_mux_diff) else $error("bad differential pair");
   a_mux_single: assert property (p_mux_single) else $error("bad common selection");
   c_conv: cover property ($rose(conv_busy));
   c_ref_on: cover property ($rose(reference_power));
   c_ref_off: cover property ($fell(reference_power));
endmodule : adc_cmd_ctrl_monitor
`default_nettype wire

// file: verification/i2c_master_model.sv
// Purpose: two-wire bus master, drives scl and releases sda
// Assumes: callers act on the falling clk edge
// Notes: sda high means released, line pulled up
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
   // clock
   input wire logic clk,
   // bus
   input wire logic sda_line,
   output logic scl,
   output logic sda
);
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end
   task automatic hold(input int n);
      repeat (n) @(negedge clk);
   endtask : hold
   task automatic start();
      sda = 1'b1;
      hold(4);
      scl = 1'b1;
      hold(6);
      sda = 1'b0;
      hold(6);
      scl = 1'b0;
      hold(93);
   endtask : start
   task automatic stop();
      sda = 1'b0;
      hold(4);
      scl = 1'b1;
      hold(6);
      sda = 1'b1;
      hold(8);
   endtask : stop
   task automatic bit_io(input logic b, output logic r);
      sda = b;
      hold(4);
      scl = 1'b1;
      hold(4);
      r = sda_line;
      hold(4);
      scl = 1'b0;
      hold(4);
   endtask : bit_io
   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
      end
      bit_io(1'b1, r);
      ack = ~r;
   endtask : wr_byte
   task automatic rd_byte(input logic nack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, d[i]);
      end
      bit_io(nack, r);
   endtask : rd_byte
endmodule : i2c_master_model
`default_nettype wire

// file: verification/test_i2c_adc_command_control.sv
// Purpose: self-checking bench for the converter command controller
// Assumes: master model on the bus, comparator modelled from vin
// Notes: expected words kept in a queue
`timescale 1ns/1ps
`default_nettype none
module test_i2c_adc_command_control;
   import adc_cmd_pkg::*;
   logic clk = 1'b0;
   logic conv_clk = 1'b0;
   logic rst = 1'b1;
   logic ash = 1'b0;
   logic asl = 1'b0;
   logic [11:0] vin = 12'h000;
   logic scl, sda_m, sda_oe, sda_o, sda_line, mux_neg_common, sample_hold;
   logic converter_power, reference_power, conv_busy, result_valid;
   logic [2:0] mux_pos_ch, mux_neg_ch;
   logic [11:0] dac_trial;
   logic sda_oe4, sda_o4, com4;
   logic [2:0] pos4, neg4;
   logic [6:0] dev;
   logic [11:0] exp_q[$];
   int fails = 0;
   int n_checks = 0;
   int seed = 96492;
   assign sda_line = sda_m & ~(sda_oe & ~sda_o) & ~(sda_oe4 & ~sda_o4);
   assign dev = {TYPE_CODE, ash, asl};
   always #20 clk = ~clk;
   initial begin
      #2.5;
      forever #6 conv_clk = ~conv_clk;
   end
   i2c_master_model i_mst (.clk(clk), .sda_line(sda_line), .scl(scl), .sda(sda_m));
   adc_cmd_ctrl #(.NUM_CHANNELS(8)) i_dut (
      .clk(clk), .rst(rst), .conv_clk(conv_clk), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
      .sda_oe(sda_oe), .address_select_high(ash), .address_select_low(asl), .cmp_high(dac_trial <= vin),
      .mux_pos_ch(mux_pos_ch), .mux_neg_ch(mux_neg_ch), .mux_neg_common(mux_neg_common),
      .dac_trial(dac_trial), .sample_hold(sample_hold), .converter_power(converter_power),
      .reference_power(reference_power), .conv_busy(conv_busy), .result_valid(result_valid)
   );
   // four-channel build on the same bus, straps inverted so no single-bit address slip reaches it
   adc_cmd_ctrl #(.NUM_CHANNELS(4)) i_dut4 (
      .clk(clk), .rst(rst), .conv_clk(conv_clk), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o4),
      .sda_oe(sda_oe4), .address_select_high(~ash), .address_select_low(~asl), .cmp_high(1'b1),
      .mux_pos_ch(pos4), .mux_neg_ch(neg4), .mux_neg_common(com4), .dac_trial(), .sample_hold(),
      .converter_power(), .reference_power(), .conv_busy(), .result_valid()
   );
   // ====
   // tasks
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : tally_and_finish
   task automatic address(input logic [6:0] a, input logic rd, output logic ack);
      i_mst.start();
      i_mst.wr_byte({a, rd}, ack);
   endtask : address
   task automatic command(input logic [7:0] c);
      logic a;
      address(dev, 1'b0, a);
      check("wr_ack", a, 1'b1);
      i_mst.wr_byte(c, a);
      check("cmd_ack", a, 1'b1);
      exp_q.push_back(vin);
   endtask : command
   task automatic read_word();
      logic a;
      logic [15:0] w;
      address(dev, 1'b1, a);
      check("rd_ack", a, 1'b1);
      i_mst.rd_byte(1'b0, w[15:8]);
      i_mst.rd_byte(1'b1, w[7:0]);
      i_mst.stop();
      check("word", w, {4'h0, (exp_q.size() > 0) ? exp_q[$] : 12'h000});
   endtask : read_word
   task automatic wait_conv();
      int k;
      k = 0;
      while (conv_busy !== 1'b0 && k < 100) begin
         @(negedge clk);
         k++;
      end
      check("busy", conv_busy, 1'b0);
      check("valid", result_valid, 1'b1);
   endtask : wait_conv
   // ====
   // sequence
   initial begin
      logic a;
      logic ref_on;
      ref_on = 1'b0;
      {ash, asl} = 2'($random(seed));
      repeat (3) @(negedge clk);
      rst = 1'b0;
      repeat (6) @(negedge clk);
      check("ref_reset", reference_power, 1'b0);
      check("valid_reset", result_valid, 1'b0);
      read_word();
      $display("test early_read done");
      for (int i = 0; i < 7; i++) begin
         address(dev ^ (7'h01 << i), 1'b0, a);
         i_mst.stop();
         check("bad_ack", a, 1'b0);
      end
      $display("test address done");
      for (int c = 0; c < 16; c++) begin
         vin = 12'($random(seed));
         command({4'(c), 4'h4});
         wait_conv();
         check("pos", mux_pos_ch, {c[1], c[0], c[2]});
         check("neg", mux_neg_ch, c[3] ? 3'h0 : {c[1], c[0], ~c[2]});
         check("com", mux_neg_common, c[3]);
         read_word();
      end
      check("ref_ext", reference_power, 1'b0);
      $display("test channels done");
      for (int p = 0; p < 4; p++) begin
         vin = 12'($random(seed));
         command({4'h8, 2'(p), 2'h0});
         check("ref_pre", reference_power, ref_on & p[1]);
         i_mst.stop();
         wait_conv();
         ref_on = p[1];
         check("ref_post", reference_power, ref_on);
         check("conv_pwr", converter_power, p[0]);
         repeat (50) @(negedge clk);
         read_word();
      end
      command(8'h84);
      check("ref_off", reference_power, 1'b0);
      i_mst.stop();
      $display("test power done");
      address(dev ^ 7'h03, 1'b0, a);
      check("ack4", a, 1'b1);
      i_mst.wr_byte(8'h44, a);
      check("mux4", {com4, pos4, neg4}, 7'h08);
      i_mst.wr_byte(8'h24, a);
      check("keep4", {com4, pos4, neg4}, 7'h08);
      i_mst.stop();
      $display("test small done");
      tally_and_finish();
   end
   initial begin
      #3_000_000;
      fails++;
      $display("watchdog expired");
      tally_and_finish();
   end
endmodule : test_i2c_adc_command_control
bind adc_cmd_ctrl adc_cmd_ctrl_monitor i_mon (
   .clk(clk), .rst(rst), .scl_i(scl_i), .sda_o(sda_o), .sda_oe(sda_oe), .mux_pos_ch(mux_pos_ch),
   .mux_neg_ch(mux_neg_ch), .mux_neg_common(mux_neg_common), .sample_hold(sample_hold),
   .converter_power(converter_power), .reference_power(reference_power), .conv_busy(conv_busy),
   .result_valid(result_valid)
);
`default_nettype wire
